// *** verilog/erictl_pkg.sv ***
// Functional notes
// RQ1 - Enable bit passes or blocks pin request
// RQ2 - Sense 0: low pin level sets flag
// RQ3 - Sense 1: falling pin edge sets flag
// RQ4 - Read flag as one, write zero clears
// RQ5 - Level mode: pin high plus ack clears
// RQ6 - Edge mode: ack clears flag
// RQ7 - Flags take only zero; reset to zero
// RQ8 - Priority bit: 0 low, 1 high; reset zero
// RQ9 - Priority A bits 7..4 map pin requests
// RQ10 - Priority A bits 3..0 watchdog and timers
// RQ11 - Priority B maps timers, dma, serial, adc
// RQ12 - High level first, then fixed source order
package erictl_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ERICTL_SENSE_OFS = 8'hF4;
  localparam logic [7:0] ERICTL_ENABLE_OFS = 8'hF5;
  localparam logic [7:0] ERICTL_FLAGS_OFS = 8'hF6;
  localparam logic [7:0] ERICTL_PRIO_A_OFS = 8'hF8;
  localparam logic [7:0] ERICTL_PRIO_B_OFS = 8'hF9;
  localparam logic [7:0] ERICTL_STATUS_OFS = 8'hFA;
  localparam logic [7:0] ERICTL_MASK_OFS = 8'hFB;

  // ----------------------------------------------------------------
  // Reset values and writable bits
  // ----------------------------------------------------------------
  localparam logic [7:0] ERICTL_REG_RST = 8'h00;
  localparam logic [7:0] ERICTL_PIN_BITS = 8'h3F;
  localparam logic [7:0] ERICTL_PRIO_B_BITS = 8'hEE;
  localparam logic [15:0] ERICTL_SRC_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Sources: 0..5 pins, then on-chip sources
  // ----------------------------------------------------------------
  localparam int ERICTL_NPIN = 6;
  localparam int ERICTL_NINT = 10;
  localparam int ERICTL_NSRC = 16;
  localparam logic [3:0] ERICTL_SRC_WATCHDOG = 4'h6;
  localparam logic [3:0] ERICTL_SRC_TIMER0 = 4'h7;
  localparam logic [3:0] ERICTL_SRC_DMA = 4'hC;
  localparam logic [3:0] ERICTL_SRC_SERIAL0 = 4'hD;
  localparam logic [3:0] ERICTL_SRC_ADC = 4'hF;

endpackage

// *** verilog/erictl_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module erictl_top
  import erictl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic [5:0] pin_req_n_i,
  input wire logic [9:0] int_req_i,
  input wire logic ack_i,
  input wire logic [3:0] ack_src_i,
  output logic irq_req_o,
  output logic [3:0] irq_src_o,
  output logic irq_level_o,
  output logic int_o
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] sense_q;
  logic [7:0] enable_q;
  logic [7:0] flag_q;
  logic [7:0] arm_q;
  logic [7:0] prio_a_q;
  logic [7:0] prio_b_q;
  logic [7:0] status_q;
  logic [7:0] mask_q;
  logic [7:0] rdata_q;
  logic [5:0] pin_s1_q;
  logic [5:0] pin_s2_q;
  logic [5:0] pin_prev_q;
  logic irq_req_q;
  logic [3:0] irq_src_q;
  logic irq_level_q;
  logic int_q;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire logic hit_sense = addr_i == ERICTL_SENSE_OFS;
  wire logic hit_enable = addr_i == ERICTL_ENABLE_OFS;
  wire logic hit_flags = addr_i == ERICTL_FLAGS_OFS;
  wire logic hit_prio_a = addr_i == ERICTL_PRIO_A_OFS;
  wire logic hit_prio_b = addr_i == ERICTL_PRIO_B_OFS;
  wire logic hit_status = addr_i == ERICTL_STATUS_OFS;
  wire logic hit_mask = addr_i == ERICTL_MASK_OFS;
  wire logic wr_flags = wr_i & hit_flags;
  wire logic rd_flags = rd_i & hit_flags;
  wire logic wr_status = wr_i & hit_status;

  // Read mux; unmapped addresses read as zero
  wire logic [7:0] rd_mux =
      hit_sense ? sense_q :
      hit_enable ? enable_q :
      hit_flags ? flag_q :
      hit_prio_a ? prio_a_q :
      hit_prio_b ? prio_b_q :
      hit_status ? status_q :
      hit_mask ? mask_q : ERICTL_REG_RST;

  // ----------------------------------------------------------------
  // Pin synchroniser and edge history
  // ----------------------------------------------------------------
  // Pins are asynchronous; edge logic only looks at the second stage
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pin_s1_q <= ERICTL_PIN_BITS[5:0];
      pin_s2_q <= ERICTL_PIN_BITS[5:0];
      pin_prev_q <= ERICTL_PIN_BITS[5:0];
    end
    else
    begin
      pin_s1_q <= pin_req_n_i;
      pin_s2_q <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end

  // ----------------------------------------------------------------
  // Per-pin flag control
  // ----------------------------------------------------------------
  logic [7:0] flag_d;
  logic [7:0] arm_d;
  logic [5:0] fall;
  logic [5:0] set_flag;
  logic [5:0] clr_sw;
  logic [5:0] clr_ack;

  genvar gi;
  generate
    for (gi = 0; gi < ERICTL_NPIN; gi++)
    begin : g_pin
      // High-to-low change seen between two synchronised samples
      assign fall[gi] = pin_prev_q[gi] & ~pin_s2_q[gi];
      // Sense bit picks low level or falling edge
      assign set_flag[gi] = sense_q[gi] ? fall[gi] : ~pin_s2_q[gi]; // RQ2 RQ3
      // Only a zero clears, and only after the flag was read as one
      assign clr_sw[gi] = wr_flags & ~wdata_i[gi] & arm_q[gi]; // RQ4 RQ7
      // Level mode needs the pin back high before ack clears
      assign clr_ack[gi] = ack_i & (ack_src_i == 4'(gi))
          & (sense_q[gi] | pin_s2_q[gi]); // RQ5 RQ6
      // Set wins over any clear landing in the same cycle
      assign flag_d[gi] = set_flag[gi]
          | (flag_q[gi] & ~(clr_sw[gi] | clr_ack[gi]));
      // Arm on a read that sees one; any flag write consumes it
      assign arm_d[gi] = (rd_flags & flag_q[gi]) | (arm_q[gi] & ~wr_flags);
    end
  endgenerate
  assign flag_d[7:6] = 2'h0;
  assign arm_d[7:6] = 2'h0;

  // Flags and their read-arm bits
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      flag_q <= ERICTL_REG_RST; // RQ7
      arm_q <= ERICTL_REG_RST;
    end
    else
    begin
      flag_q <= flag_d;
      arm_q <= arm_d;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  // Unused bits are masked on write so they always read zero
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      sense_q <= ERICTL_REG_RST;
      enable_q <= ERICTL_REG_RST; // RQ1
      prio_a_q <= ERICTL_REG_RST; // RQ8
      prio_b_q <= ERICTL_REG_RST;
      mask_q <= ERICTL_REG_RST;
    end
    else if (wr_i)
    begin
      if (hit_sense)
        sense_q <= wdata_i & ERICTL_PIN_BITS;
      if (hit_enable)
        enable_q <= wdata_i & ERICTL_PIN_BITS;
      if (hit_prio_a)
        prio_a_q <= wdata_i;
      if (hit_prio_b)
        prio_b_q <= wdata_i & ERICTL_PRIO_B_BITS;
      if (hit_mask)
        mask_q <= wdata_i & ERICTL_PIN_BITS;
    end
  end

  // ----------------------------------------------------------------
  // Event status: a flag going from 0 to 1, write one to clear
  // ----------------------------------------------------------------
  wire logic [7:0] new_evt = {2'h0, set_flag & ~flag_q[5:0]};
  wire logic [7:0] stat_clr = wr_status ? wdata_i : ERICTL_REG_RST;
  wire logic [7:0] status_d = new_evt | (status_q & ~stat_clr);

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      status_q <= ERICTL_REG_RST;
    else
      status_q <= status_d;
  end

  // ----------------------------------------------------------------
  // Source level map and arbitration
  // ----------------------------------------------------------------
  // Pins 2/3 and 4/5 share a level bit each
  wire logic [15:0] lvl_vec = {
      prio_b_q[1], prio_b_q[2], prio_b_q[3], prio_b_q[5], // RQ11
      prio_b_q[6], prio_b_q[7],
      prio_a_q[0], prio_a_q[1], prio_a_q[2], prio_a_q[3], // RQ10
      prio_a_q[4], prio_a_q[4], prio_a_q[5], prio_a_q[5], // RQ9
      prio_a_q[6], prio_a_q[7]};
  // A disabled pin never reaches the arbiter
  wire logic [15:0] pend = {int_req_i, flag_q[5:0] & enable_q[5:0]}; // RQ1
  wire logic [15:0] pend_hi = pend & lvl_vec;
  wire logic [15:0] pend_sel = (|pend_hi) ? pend_hi : pend; // RQ8 RQ12

  // Lowest index wins inside the chosen level
  logic [3:0] win_src;
  always_comb
  begin
    win_src = 4'h0;
    for (int i = ERICTL_NSRC - 1; i >= 0; i--)
    begin
      if (pend_sel[i])
        win_src = 4'(i); // RQ12
    end
  end

  // Registered request towards the cpu and the level interrupt
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      irq_req_q <= ERICTL_REG_RST[0];
      irq_src_q <= ERICTL_SRC_RST[3:0];
      irq_level_q <= ERICTL_REG_RST[0];
      int_q <= ERICTL_REG_RST[0];
    end
    else
    begin
      irq_req_q <= |pend;
      irq_src_q <= win_src;
      irq_level_q <= |pend_hi;
      int_q <= |(status_d & mask_q);
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      rdata_q <= ERICTL_REG_RST;
    else
      rdata_q <= rd_i ? rd_mux : ERICTL_REG_RST;
  end

  assign rdata_o = rdata_q;
  assign irq_req_o = irq_req_q;
  assign irq_src_o = irq_src_q;
  assign irq_level_o = irq_level_q;
  assign int_o = int_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_enable_block;
    (enable_q == ERICTL_REG_RST) && (int_req_i == 10'h000) |=> !irq_req_o;
  endproperty
  a_enable_block: assert property (p_enable_block) // RQ1
    else $error("disabled pins raised a request");

  property p_level_set;
    !sense_q[0] && !pin_s2_q[0] |=> flag_q[0];
  endproperty
  a_level_set: assert property (p_level_set) // RQ2
    else $error("low level did not set flag");

  property p_edge_set;
    sense_q[0] && pin_prev_q[0] && !pin_s2_q[0] |=> flag_q[0];
  endproperty
  a_edge_set: assert property (p_edge_set) // RQ3
    else $error("falling edge did not set flag");

  sequence s_read_one;
    rd_flags && flag_q[0];
  endsequence
  sequence s_write_zero;
    wr_flags && !wdata_i[0] && !set_flag[0];
  endsequence
  property p_read_clear;
    s_read_one ##1 s_write_zero |=> !flag_q[0];
  endproperty
  a_read_clear: assert property (p_read_clear) // RQ4
    else $error("read then write zero did not clear");

  property p_one_no_effect;
    wr_flags && wdata_i[0] && !flag_q[0] && !set_flag[0] |=> !flag_q[0];
  endproperty
  a_one_no_effect: assert property (p_one_no_effect) // RQ7
    else $error("writing one changed a flag");

  property p_level_ack;
    ack_i && ack_src_i == 4'h0 && !sense_q[0] && pin_s2_q[0] |=> !flag_q[0];
  endproperty
  a_level_ack: assert property (p_level_ack) // RQ5
    else $error("level ack did not clear");

  property p_edge_ack;
    ack_i && ack_src_i == 4'h0 && sense_q[0] && !fall[0] |=> !flag_q[0];
  endproperty
  a_edge_ack: assert property (p_edge_ack) // RQ6
    else $error("edge ack did not clear");

  property p_map_pins;
    pend == 16'h0008 |=> irq_level_o == $past(prio_a_q[5]);
  endproperty
  a_map_pins: assert property (p_map_pins) // RQ9
    else $error("pin 3 level not from bit 5");

  property p_map_watchdog;
    pend == 16'h0040 |=> irq_level_o == $past(prio_a_q[3]);
  endproperty
  a_map_watchdog: assert property (p_map_watchdog) // RQ10
    else $error("watchdog level not from bit 3");

  property p_map_dma;
    pend == 16'h1000 |=> irq_level_o == $past(prio_b_q[5]) ##0 irq_src_o == ERICTL_SRC_DMA;
  endproperty
  a_map_dma: assert property (p_map_dma) // RQ11
    else $error("dma level not from bit 5");

  property p_high_first;
    pend[15] && lvl_vec[15] && !(|(pend_hi[14:0])) |=> irq_src_o == ERICTL_SRC_ADC;
  endproperty
  a_high_first: assert property (p_high_first) // RQ12
    else $error("high level source lost arbitration");

  property p_prio_reset;
    $rose(rst_n_i) |-> prio_a_q == ERICTL_REG_RST;
  endproperty
  a_prio_reset: assert property (@(posedge clk_i) p_prio_reset) // RQ8
    else $error("priority register not cleared");

  // An enabled pending pin must reach the request output
  property p_enable_pass;
    flag_q[0] && enable_q[0] |=> irq_req_o;
  endproperty
  a_enable_pass: assert property (p_enable_pass) // RQ1
    else $error("enabled pin did not raise a request");

  // Status is sticky: a new flag event always lands
  property p_status_set;
    new_evt[0] |=> status_q[0];
  endproperty
  a_status_set: assert property (p_status_set)
    else $error("flag event did not set status");

  // Writing one clears status when no new event clashes with it
  property p_status_clear;
    wr_status && wdata_i[0] && !new_evt[0] |=> !status_q[0];
  endproperty
  a_status_clear: assert property (p_status_clear)
    else $error("write one did not clear status");

  // Level interrupt follows the next status under the mask
  property p_int_level;
    |(status_d & mask_q) |=> int_o;
  endproperty
  a_int_level: assert property (p_int_level)
    else $error("unmasked status did not raise interrupt");

endmodule
`default_nettype wire

// *** test/erictl_pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module erictl_pin_model
(
  input wire logic clk_i,
  input wire logic [5:0] low_i,
  output logic [5:0] pin_req_n_o
);
  // Far-side devices pull a line low to request; released lines idle high.
  // Changes land on the falling edge, half a cycle away from the core's sampling edge
  always_ff @(negedge clk_i)
  begin
    pin_req_n_o <= ~low_i;
  end
endmodule
`default_nettype wire

// *** test/test_external_request_interrupt_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_external_request_interrupt_ctrl;
  import erictl_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [5:0] pin_low = 6'h00;
  logic [9:0] int_req_i = 10'h000;
  logic ack_i = 1'b0;
  logic [3:0] ack_src_i = 4'h0;
  wire [7:0] rdata_o;
  wire [5:0] pin_req_n;
  wire irq_req_o;
  wire [3:0] irq_src_o;
  wire irq_level_o;
  wire int_o;
  int num_errors = 0;
  int comparisons = 0;
  // Priority bit that raises each on-chip source, in source order
  logic [7:0] pa [10] = '{8'h08, 8'h04, 8'h02, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] pb [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h40, 8'h20, 8'h08, 8'h04, 8'h02};
  logic [7:0] pp [6] = '{8'h80, 8'h40, 8'h20, 8'h20, 8'h10, 8'h10};

  erictl_pin_model pins (.clk_i(clk_i), .low_i(pin_low), .pin_req_n_o(pin_req_n));
  erictl_top uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_req_n_i(pin_req_n),
    .int_req_i(int_req_i), .ack_i(ack_i), .ack_src_i(ack_src_i), .irq_req_o(irq_req_o),
    .irq_src_o(irq_src_o), .irq_level_o(irq_level_o), .int_o(int_o));

  // ----------------------------------------------------------------
  // Clock, bus and compare tasks
  // ----------------------------------------------------------------
  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Arbiter outputs packed as req, level, source
  task automatic chk_irq(input logic req, input logic [3:0] src, input logic lvl);
    chk({2'b00, irq_req_o, irq_level_o, irq_src_o}, {2'b00, req, lvl, src});
  endtask

  task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic set_pins(input logic [5:0] v);
    @(posedge clk_i);
    pin_low <= v;
    cyc(6);
  endtask

  task automatic ack(input logic [3:0] s);
    @(posedge clk_i);
    ack_i <= 1'b1;
    ack_src_i <= s;
    @(posedge clk_i);
    ack_i <= 1'b0;
    cyc(2);
  endtask

  task automatic tally_and_finish();
    if (num_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd_chk(ERICTL_ENABLE_OFS, ERICTL_REG_RST);
    rd_chk(ERICTL_FLAGS_OFS, 8'h00);
    rd_chk(ERICTL_PRIO_A_OFS, 8'h00);
    rd_chk(8'hF7, 8'h00);
    bus_write(ERICTL_PRIO_B_OFS, 8'hFF);
    rd_chk(ERICTL_PRIO_B_OFS, ERICTL_PRIO_B_BITS);
    bus_write(ERICTL_FLAGS_OFS, 8'hFF);
    rd_chk(ERICTL_FLAGS_OFS, 8'h00);
    bus_write(ERICTL_PRIO_B_OFS, 8'h00);
    // Level sense; pin 1 pends while its enable is off
    bus_write(ERICTL_ENABLE_OFS, 8'hFD);
    rd_chk(ERICTL_ENABLE_OFS, 8'h3D);
    set_pins(6'h02);
    rd_chk(ERICTL_FLAGS_OFS, 8'h02);
    chk_irq(1'b0, 4'h0, 1'b0);
    set_pins(6'h03);
    chk_irq(1'b1, 4'h0, 1'b0);
    // Sticky status, mask and the level interrupt
    rd_chk(ERICTL_STATUS_OFS, 8'h03);
    chk({7'h00, int_o}, 8'h00);
    bus_write(ERICTL_MASK_OFS, 8'h01);
    cyc(2);
    chk({7'h00, int_o}, 8'h01);
    bus_write(ERICTL_STATUS_OFS, 8'h03);
    cyc(2);
    chk({7'h00, int_o}, 8'h00);
    rd_chk(ERICTL_STATUS_OFS, 8'h00);
    // Ack is ignored while the pin is still low
    ack(4'h0);
    rd_chk(ERICTL_FLAGS_OFS, 8'h03);
    set_pins(6'h02);
    rd_chk(ERICTL_FLAGS_OFS, 8'h03);
    ack(4'h0);
    rd_chk(ERICTL_FLAGS_OFS, 8'h02);
    chk_irq(1'b0, 4'h0, 1'b0);
    // Edge sense on pin 2: ack clears although the pin stays low
    bus_write(ERICTL_SENSE_OFS, 8'h04);
    set_pins(6'h06);
    rd_chk(ERICTL_FLAGS_OFS, 8'h06);
    ack(4'h2);
    rd_chk(ERICTL_FLAGS_OFS, 8'h02);
    // Software clear needs a fresh read as one
    set_pins(6'h02);
    set_pins(6'h06);
    rd_chk(ERICTL_FLAGS_OFS, 8'h06);
    bus_write(ERICTL_FLAGS_OFS, 8'hFF);
    bus_write(ERICTL_FLAGS_OFS, 8'hFB);
    rd_chk(ERICTL_FLAGS_OFS, 8'h06);
    bus_write(ERICTL_FLAGS_OFS, 8'hFB);
    rd_chk(ERICTL_FLAGS_OFS, 8'h02);
    set_pins(6'h00);
    ack(4'h1);
    rd_chk(ERICTL_FLAGS_OFS, 8'h00);
    // Each on-chip source raised alone beats lower-index peers
    @(posedge clk_i);
    int_req_i <= 10'h3FF;
    for (int i = 0; i < 10; i++)
    begin
      bus_write(ERICTL_PRIO_A_OFS, pa[i]);
      bus_write(ERICTL_PRIO_B_OFS, pb[i]);
      cyc(2);
      chk_irq(1'b1, 4'(6 + i), 1'b1);
    end
    bus_write(ERICTL_PRIO_B_OFS, 8'h00);
    cyc(2);
    chk_irq(1'b1, ERICTL_SRC_WATCHDOG, 1'b0);
    // Pin priority bits against a raised timer channel 3
    bus_write(ERICTL_SENSE_OFS, 8'h3F);
    bus_write(ERICTL_ENABLE_OFS, 8'h3F);
    bus_write(ERICTL_PRIO_B_OFS, 8'h80);
    for (int k = 0; k < 6; k++)
    begin
      set_pins(6'(1 << k));
      chk_irq(1'b1, 4'hA, 1'b1);
      bus_write(ERICTL_PRIO_A_OFS, pp[k]);
      cyc(2);
      chk_irq(1'b1, 4'(k), 1'b1);
      ack(4'(k));
      chk_irq(1'b1, 4'hA, 1'b1);
      bus_write(ERICTL_PRIO_A_OFS, 8'h00);
      set_pins(6'h00);
    end
    // Single sources alone, so each level map is seen in isolation
    @(posedge clk_i);
    int_req_i <= 10'h001;
    bus_write(ERICTL_PRIO_A_OFS, 8'h08);
    cyc(2);
    chk_irq(1'b1, ERICTL_SRC_WATCHDOG, 1'b1);
    @(posedge clk_i);
    int_req_i <= 10'h040;
    bus_write(ERICTL_PRIO_B_OFS, 8'h20);
    cyc(2);
    chk_irq(1'b1, ERICTL_SRC_DMA, 1'b1);
    @(posedge clk_i);
    int_req_i <= 10'h000;
    bus_write(ERICTL_PRIO_A_OFS, 8'h20);
    set_pins(6'h08);
    chk_irq(1'b1, 4'h3, 1'b1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
